// *** haptic_pattern_ram_sequencer_tb.sv ***
// Self-checking bench for the pattern RAM sequencer, host model on the register port.
// Assumes a short slot parameter so each playback fits in a few hundred cycles.
`timescale 1ns/100ps
module haptic_pattern_ram_sequencer_tb;
  import hprs_pkg::*;
  logic mclk, reset_n, reg_wr, reg_rd, drive_direction_q, auto_brake_q, playback_busy_q;
  logic [7:0] reg_addr, reg_wdata, reg_rdata_q, rv;
  logic [6:0] drive_amplitude_q;
  int n_errors = 0;
  int total_checks = 0;
  int cycles = 0;
  int e1, e2, k, d;
  hprs_sequencer #(.SLOT_CYCLES(4)) dut_u (.mclk(mclk), .reset_n(reset_n), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q),
    .drive_amplitude_q(drive_amplitude_q), .drive_direction_q(drive_direction_q),
    .auto_brake_q(auto_brake_q), .playback_busy_q(playback_busy_q));
  hprs_host_model host_u (.mclk(mclk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q));
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  task automatic complete_run;
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      complete_run();
    end
  end
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    host_u.rd(a, rv);
    chk8(rv, exp);
  endtask
  function automatic logic [23:0] smp(input logic [1:0] sq, input logic dr,
    input logic [6:0] am, input logic [4:0] du, input logic [4:0] wt, input logic [3:0] rp);
    return {sq, dr, am, du, wt, rp};
  endfunction
  task automatic put(input logic [7:0] a, input logic [23:0] s);
    host_u.wr(HPRS_ADDR_RAM_PTR, a);
    host_u.wr(HPRS_ADDR_DATA_H, s[23:16]);
    host_u.wr(HPRS_ADDR_DATA_M, s[15:8]);
    host_u.wr(HPRS_ADDR_DATA_L, s[7:0]);
  endtask
  task automatic back(input logic [7:0] a, input logic [23:0] s);
    host_u.wr(HPRS_ADDR_RAM_PTR, a);
    rchk(HPRS_ADDR_DATA_H, s[23:16]);
    rchk(HPRS_ADDR_DATA_M, s[15:8]);
    rchk(HPRS_ADDR_DATA_L, s[7:0]);
  endtask
  // Counts entries into two watched {direction, amplitude} values
  task automatic run(input logic [7:0] st, v1, v2, output int e1, e2, k, d);
    logic [7:0] cur, prev;
    d = 0;
    e1 = 0;
    e2 = 0;
    k = 0;
    prev = 8'h00;
    host_u.wr(HPRS_ADDR_PAT_START, st);
    host_u.wr(HPRS_ADDR_CONTROL, 8'h72);
    host_u.wr(HPRS_ADDR_CONTROL, 8'hf2);
    repeat (300) begin
      @(posedge mclk) #1;
      cur = {drive_direction_q, drive_amplitude_q};
      e1 += int'(cur === v1 && prev !== v1);
      e2 += int'(cur === v2 && prev !== v2);
      k += int'(auto_brake_q === 1'b1);
      d += int'(drive_amplitude_q !== 7'h00);
      prev = cur;
    end
    chk8({7'h00, playback_busy_q}, 8'h00);
    host_u.wr(HPRS_ADDR_CONTROL, 8'h72);
  endtask
  task automatic t_regs;
    rchk(HPRS_ADDR_CONTROL, 8'h00);
    rchk(HPRS_ADDR_PAT_START, 8'h00);
    rchk(8'h3f, 8'h00);
    host_u.wr(HPRS_ADDR_CONTROL, 8'h40);
    put(8'hff, smp(2'h1, 1'b1, 7'h5a, 5'h1f, 5'h11, 4'hc));
    put(8'h00, smp(2'h2, 1'b0, 7'h25, 5'h0a, 5'h0e, 4'h3));
    rchk(HPRS_ADDR_RAM_PTR, 8'h00);
    host_u.wr(HPRS_ADDR_RAM_PTR, 8'h5c);
    rchk(HPRS_ADDR_RAM_PTR, 8'h5c);
    back(8'hff, smp(2'h1, 1'b1, 7'h5a, 5'h1f, 5'h11, 4'hc));
    back(8'h00, smp(2'h2, 1'b0, 7'h25, 5'h0a, 5'h0e, 4'h3));
    host_u.wr(HPRS_ADDR_CONTROL, 8'h00);
    put(8'hff, 24'h123456);
    host_u.wr(HPRS_ADDR_CONTROL, 8'h40);
    back(8'hff, smp(2'h1, 1'b1, 7'h5a, 5'h1f, 5'h11, 4'hc));
    $display("test registers done");
  endtask
  task automatic t_play;
    put(8'h20, smp(HPRS_SEQ_NEXT, 1'b0, 7'h55, 5'h02, 5'h01, 4'h1));
    put(8'h21, smp(HPRS_SEQ_LAST, 1'b1, 7'h2a, 5'h01, 5'h02, 4'h0));
    run(8'h20, 8'h55, 8'haa, e1, e2, k, d);
    chk8(8'(e1), 8'h02);
    chk8(8'(e2), 8'h01);
    chk8(8'(k), 8'h08);
    chk8(8'(d), 8'h14);
    put(8'h30, smp(HPRS_SEQ_INTERP, 1'b0, 7'h10, 5'h02, 5'h00, 4'h0));
    put(8'h31, smp(HPRS_SEQ_LAST_REPEAT, 1'b0, 7'h40, 5'h01, 5'h00, 4'h1));
    run(8'h30, 8'h28, 8'h40, e1, e2, k, d);
    chk8(8'(e1), 8'h02);
    chk8(8'(d), 8'h18);
    chk8(8'(e2), 8'h02);
    chk8(8'(k), 8'h00);
    $display("test playback done");
  endtask
  task automatic t_abort;
    host_u.wr(HPRS_ADDR_CONTROL, 8'hf2);
    repeat (6) @(posedge mclk);
    #1;
    chk8({7'h00, playback_busy_q}, 8'h01);
    host_u.wr(HPRS_ADDR_CONTROL, 8'h60);
    repeat (2) @(posedge mclk);
    #1;
    chk8({playback_busy_q, drive_amplitude_q}, 8'h00);
    host_u.wr(HPRS_ADDR_CONTROL, 8'h00);
    $display("test abort done");
  endtask
  initial begin
    reset_n = 1'b0;
    repeat (12) @(posedge mclk);
    #1;
    reset_n = 1'b1;
    t_regs();
    t_play();
    t_abort();
    complete_run();
  end
endmodule

// *** hprs_host_model.sv ***
// Host model: byte register master standing in for the serial host.
// Assumes the bench waits for reset release before calling any task.
`timescale 1ns/100ps
module hprs_host_model (
  input wire logic mclk, // Clock
  output logic reg_wr, // Write strobe
  output logic reg_rd, // Read strobe
  output logic [7:0] reg_addr, // Address
  output logic [7:0] reg_wdata, // Write data
  input wire logic [7:0] reg_rdata_q // Read data
);
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end
  // Released lines show the inverse, never the last value
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk) #1;
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge mclk) #1;
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk) #1;
    reg_addr = a;
    reg_rd = 1'b1;
    @(posedge mclk) #1;
    reg_rd = 1'b0;
    reg_addr = ~a;
    d = reg_rdata_q;
  endtask
endmodule

// *** hprs_pkg.sv ***
// Constants for the haptic pattern RAM sequencer.
// Assumes one 200 MHz clock; register offsets are byte register addresses.
package hprs_pkg;
  // Register addresses
  localparam logic [7:0] HPRS_ADDR_CONTROL = 8'h09;
  localparam logic [7:0] HPRS_ADDR_PAT_START = 8'h0b;
  localparam logic [7:0] HPRS_ADDR_RAM_PTR = 8'h40;
  localparam logic [7:0] HPRS_ADDR_DATA_H = 8'h41;
  localparam logic [7:0] HPRS_ADDR_DATA_M = 8'h42;
  localparam logic [7:0] HPRS_ADDR_DATA_L = 8'h43;
  // Reset values
  localparam logic [7:0] HPRS_RST_BYTE = 8'h00;
  // haptic_control fields
  localparam int HPRS_CTL_TRIG_BIT = 7;
  localparam int HPRS_CTL_RAMEN_BIT = 6;
  localparam int HPRS_CTL_CLKEN_BIT = 5;
  localparam int HPRS_CTL_MODE_MSB = 4;
  localparam logic [4:0] HPRS_MODE_OFF = 5'h00;
  localparam logic [4:0] HPRS_MODE_RAM_PLAYBACK = 5'h12;
  // 24-bit sample fields
  localparam int HPRS_SEQ_MSB = 23;
  localparam int HPRS_SEQ_LSB = 22;
  localparam int HPRS_DIR_BIT = 21;
  localparam int HPRS_AMP_MSB = 20;
  localparam int HPRS_AMP_LSB = 14;
  localparam int HPRS_DUR_MSB = 13;
  localparam int HPRS_DUR_LSB = 9;
  localparam int HPRS_WAIT_MSB = 8;
  localparam int HPRS_WAIT_LSB = 4;
  localparam int HPRS_RPT_MSB = 3;
  localparam int HPRS_RPT_LSB = 0;
  // Sequence control codes
  localparam logic [1:0] HPRS_SEQ_LAST = 2'h0;
  localparam logic [1:0] HPRS_SEQ_NEXT = 2'h1;
  localparam logic [1:0] HPRS_SEQ_INTERP = 2'h2;
  localparam logic [1:0] HPRS_SEQ_LAST_REPEAT = 2'h3;
  localparam logic [3:0] HPRS_RPT_NONE = 4'h0;
  // Timing
  localparam int HPRS_SLOT_TIME_MS = 5;
  localparam int HPRS_CLK_KHZ = 200000;
  localparam int HPRS_SLOT_CYCLES = HPRS_SLOT_TIME_MS * HPRS_CLK_KHZ;
  localparam int HPRS_RAM_DEPTH = 256;
  typedef enum logic [2:0] {
    HPRS_ST_IDLE,
    HPRS_ST_LOAD,
    HPRS_ST_DRIVE,
    HPRS_ST_WAIT
  } hprs_state_e;
endpackage

// *** hprs_sequencer.sv ***
// Pattern RAM, its register access and the stored-pattern playback sequencer.
// Assumes an I2C slave upstream that turns transactions into byte register
// strobes on mclk; amplitude outputs feed the H-bridge drive stage.
`timescale 1ns/100ps

// How it works
// - RAM pointer write selects the location later sample byte writes land in.
// - After setting the pointer, reads of the three byte registers return that sample.
// - High byte: sequence control 7:6, direction 5, amplitude 6:2 in 4:0.
// - Middle byte: amplitude 1:0 in 7:6, duration 5:1, wait bit 4 in 0.
// - Low byte: wait 3:0 upper nibble, repeat count lower nibble.
// - Sequence control 00 last, 01 next, 10 interpolate, 11 last and repeat pattern.
// - Seven-bit amplitude is a share of full scale; direction picks polarity.
// - Amplitude is driven for duration code times 5 ms.
// - Then zero amplitude is held for wait code times 5 ms.
// - Repeat count replays the sample, or the whole pattern under code 11.
// - Repeat 0000 with control 00 brakes automatically during the wait time.
// - RAM holds 256 24-bit samples; start pointer sets the playback start.
// - In mode 10010 with clock enable bit 5 set, a rising software trigger starts playback.
module hprs_sequencer
  import hprs_pkg::*;
#(
  parameter int SLOT_CYCLES = HPRS_SLOT_CYCLES
) (
  input wire logic mclk, // 200 MHz clock
  input wire logic reset_n, // Asynchronous reset, active low
  input wire logic reg_wr, // Register write strobe
  input wire logic reg_rd, // Register read strobe
  input wire logic [7:0] reg_addr, // Register address
  input wire logic [7:0] reg_wdata, // Register write data
  output logic [7:0] reg_rdata_q, // Read data, valid the cycle after reg_rd
  output logic [6:0] drive_amplitude_q, // Output amplitude, share of full scale
  output logic drive_direction_q, // Output polarity, 1 negative
  output logic auto_brake_q, // Automatic braking request
  output logic playback_busy_q // Pattern playback in progress
);
  logic [7:0] control_q;
  logic [7:0] pat_start_q;
  logic [7:0] ram_ptr_q;
  logic [7:0] mem_h [HPRS_RAM_DEPTH];
  logic [7:0] mem_m [HPRS_RAM_DEPTH];
  logic [7:0] mem_l [HPRS_RAM_DEPTH];
  hprs_state_e state_q, state_d;
  logic [7:0] play_addr_q, play_addr_d;
  logic [23:0] cur_q, cur_d;
  logic [23:0] nxt_q, nxt_d;
  logic [3:0] rep_left_q, rep_left_d;
  logic [3:0] pat_rep_q, pat_rep_d;
  logic [4:0] slot_q, slot_d;
  logic [23:0] tick_cnt_q;
  logic trig_prev_q;

  function automatic logic [23:0] read_sample(input logic [7:0] h,
                                              input logic [7:0] m,
                                              input logic [7:0] l);
    read_sample = {h, m, l};
  endfunction

  function automatic logic signed [8:0] signed_amp(input logic [23:0] s);
    logic [6:0] a;
    a = s[HPRS_AMP_MSB:HPRS_AMP_LSB];
    signed_amp = s[HPRS_DIR_BIT] ? -$signed({2'b00, a}) : $signed({2'b00, a});
  endfunction

  // Register decode
  wire wr_ctl = reg_wr && (reg_addr == HPRS_ADDR_CONTROL);
  wire wr_start = reg_wr && (reg_addr == HPRS_ADDR_PAT_START);
  wire wr_ptr = reg_wr && (reg_addr == HPRS_ADDR_RAM_PTR);
  wire ram_en = control_q[HPRS_CTL_RAMEN_BIT];
  wire wr_h = reg_wr && (reg_addr == HPRS_ADDR_DATA_H) && ram_en;
  wire wr_m = reg_wr && (reg_addr == HPRS_ADDR_DATA_M) && ram_en;
  wire wr_l = reg_wr && (reg_addr == HPRS_ADDR_DATA_L) && ram_en;
  wire [7:0] rd_mux =
    (reg_addr == HPRS_ADDR_CONTROL) ? control_q :
    (reg_addr == HPRS_ADDR_PAT_START) ? pat_start_q :
    (reg_addr == HPRS_ADDR_RAM_PTR) ? ram_ptr_q :
    (reg_addr == HPRS_ADDR_DATA_H) ? mem_h[ram_ptr_q] :
    (reg_addr == HPRS_ADDR_DATA_M) ? mem_m[ram_ptr_q] :
    (reg_addr == HPRS_ADDR_DATA_L) ? mem_l[ram_ptr_q] : HPRS_RST_BYTE;

  // Playback qualifiers
  wire [4:0] mode = control_q[HPRS_CTL_MODE_MSB:0];
  wire play_mode = control_q[HPRS_CTL_CLKEN_BIT] && (mode == HPRS_MODE_RAM_PLAYBACK);
  wire trig_rise = control_q[HPRS_CTL_TRIG_BIT] && !trig_prev_q;
  wire tick = (tick_cnt_q == 24'(SLOT_CYCLES - 1));
  wire [1:0] seq = cur_q[HPRS_SEQ_MSB:HPRS_SEQ_LSB];
  wire [4:0] dur = cur_q[HPRS_DUR_MSB:HPRS_DUR_LSB];
  wire [4:0] wait_code = cur_q[HPRS_WAIT_MSB:HPRS_WAIT_LSB];
  wire [3:0] rpt = cur_q[HPRS_RPT_MSB:HPRS_RPT_LSB];
  wire [7:0] addr_inc = play_addr_q + 8'h01;
  wire [23:0] ram_at_addr = read_sample(mem_h[play_addr_q], mem_m[play_addr_q],
                                        mem_l[play_addr_q]);
  wire [23:0] ram_at_next = read_sample(mem_h[addr_inc], mem_m[addr_inc], mem_l[addr_inc]);
  wire slot_end_drive = (slot_q == dur);
  wire slot_end_wait = (slot_q == wait_code);

  // Interpolated signed amplitude
  wire signed [8:0] amp_cur = signed_amp(cur_q);
  wire signed [8:0] amp_nxt = signed_amp(nxt_q);
  wire signed [15:0] ramp_prod = 16'(amp_nxt - amp_cur) * $signed({11'h000, slot_q});
  wire signed [15:0] ramp_step = (dur == 5'h00) ? 16'sh0000 :
                                 ramp_prod / $signed({11'h000, dur});
  wire signed [8:0] amp_interp = amp_cur + 9'(ramp_step);
  wire signed [8:0] amp_sel = (seq == HPRS_SEQ_INTERP) ? amp_interp : amp_cur;
  wire [8:0] amp_mag = amp_sel[8] ? 9'(-amp_sel) : amp_sel;

  always_comb begin
    state_d = state_q;
    play_addr_d = play_addr_q;
    cur_d = cur_q;
    nxt_d = nxt_q;
    rep_left_d = rep_left_q;
    pat_rep_d = pat_rep_q;
    slot_d = slot_q;
    case (state_q)
      HPRS_ST_IDLE: begin
        if (play_mode && trig_rise) begin
          play_addr_d = pat_start_q;
          pat_rep_d = HPRS_RPT_NONE;
          state_d = HPRS_ST_LOAD;
        end
      end
      HPRS_ST_LOAD: begin
        cur_d = ram_at_addr;
        nxt_d = ram_at_next;
        rep_left_d = ram_at_addr[HPRS_RPT_MSB:HPRS_RPT_LSB];
        slot_d = 5'h00;
        state_d = HPRS_ST_DRIVE;
      end
      HPRS_ST_DRIVE: begin
        if (slot_end_drive) begin
          slot_d = 5'h00;
          state_d = HPRS_ST_WAIT;
        end else if (tick) begin
          slot_d = slot_q + 5'h01;
        end
      end
      HPRS_ST_WAIT: begin
        if (!slot_end_wait) begin
          if (tick) begin
            slot_d = slot_q + 5'h01;
          end
        end else if (seq != HPRS_SEQ_LAST_REPEAT && rep_left_q != HPRS_RPT_NONE) begin
          rep_left_d = rep_left_q - 4'h1;
          slot_d = 5'h00;
          state_d = HPRS_ST_DRIVE;
        end else if (seq == HPRS_SEQ_NEXT || seq == HPRS_SEQ_INTERP) begin
          play_addr_d = addr_inc;
          state_d = HPRS_ST_LOAD;
        end else if (seq == HPRS_SEQ_LAST_REPEAT && pat_rep_q != rpt) begin
          pat_rep_d = pat_rep_q + 4'h1;
          play_addr_d = pat_start_q;
          state_d = HPRS_ST_LOAD;
        end else begin
          state_d = HPRS_ST_IDLE;
        end
      end
      default: state_d = HPRS_ST_IDLE;
    endcase
    if (!play_mode) begin
      state_d = HPRS_ST_IDLE;
    end
  end

  // Host registers
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      control_q <= HPRS_RST_BYTE;
      pat_start_q <= HPRS_RST_BYTE;
      ram_ptr_q <= HPRS_RST_BYTE;
      trig_prev_q <= 1'b0;
      reg_rdata_q <= HPRS_RST_BYTE;
    end else begin
      if (wr_ctl) control_q <= reg_wdata;
      if (wr_start) pat_start_q <= reg_wdata;
      if (wr_ptr) ram_ptr_q <= reg_wdata;
      trig_prev_q <= control_q[HPRS_CTL_TRIG_BIT];
      if (reg_rd) reg_rdata_q <= rd_mux;
    end
  end

  // Pattern RAM, no reset
  always_ff @(posedge mclk) begin
    if (wr_h) mem_h[ram_ptr_q] <= reg_wdata;
    if (wr_m) mem_m[ram_ptr_q] <= reg_wdata;
    if (wr_l) mem_l[ram_ptr_q] <= reg_wdata;
  end

  // Sequencer state
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= HPRS_ST_IDLE;
      play_addr_q <= HPRS_RST_BYTE;
      cur_q <= 24'h000000;
      nxt_q <= 24'h000000;
      rep_left_q <= HPRS_RPT_NONE;
      pat_rep_q <= HPRS_RPT_NONE;
      slot_q <= 5'h00;
    end else begin
      state_q <= state_d;
      play_addr_q <= play_addr_d;
      cur_q <= cur_d;
      nxt_q <= nxt_d;
      rep_left_q <= rep_left_d;
      pat_rep_q <= pat_rep_d;
      slot_q <= slot_d;
    end
  end

  // Slot prescaler restarts with every slot count change
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      tick_cnt_q <= 24'h000000;
    end else if (tick || slot_d != slot_q || state_d != state_q) begin
      tick_cnt_q <= 24'h000000;
    end else begin
      tick_cnt_q <= tick_cnt_q + 24'h000001;
    end
  end

  // Drive outputs
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      drive_amplitude_q <= 7'h00;
      drive_direction_q <= 1'b0;
      auto_brake_q <= 1'b0;
      playback_busy_q <= 1'b0;
    end else begin
      playback_busy_q <= (state_d != HPRS_ST_IDLE);
      // Entry cycle of every drive skipped so amplitude lasts exactly dur slots
      if (state_d == HPRS_ST_DRIVE && state_q == HPRS_ST_DRIVE) begin
        drive_amplitude_q <= amp_mag[6:0];
        drive_direction_q <= amp_sel[8];
      end else begin
        drive_amplitude_q <= 7'h00;
        drive_direction_q <= 1'b0;
      end
      auto_brake_q <= (state_q == HPRS_ST_WAIT) && (state_d == HPRS_ST_WAIT) &&
                      (seq == HPRS_SEQ_LAST) && (rpt == HPRS_RPT_NONE);
    end
  end
endmodule

// *** hprs_sequencer_props.sv ***
// Checker for the sequencer's register port and playback outputs.
// Assumes it is bound to hprs_sequencer and sees its ports only.
`timescale 1ns/100ps
module hprs_sequencer_props
  import hprs_pkg::*;
#(
  parameter int SLOT_CYCLES = HPRS_SLOT_CYCLES
) (
  input wire logic mclk, // Clock
  input wire logic reset_n, // Reset, active low
  input wire logic reg_wr, // Write strobe
  input wire logic reg_rd, // Read strobe
  input wire logic [7:0] reg_addr, // Address
  input wire logic [7:0] reg_wdata, // Write data
  input wire logic [7:0] reg_rdata_q, // Read data
  input wire logic [6:0] drive_amplitude_q, // Amplitude
  input wire logic drive_direction_q, // Polarity
  input wire logic auto_brake_q, // Brake flag
  input wire logic playback_busy_q // Busy
);
  logic [7:0] ctl_q;
  logic ctl_wr, mapped, trig_wr;
  assign ctl_wr = reg_wr && reg_addr == HPRS_ADDR_CONTROL;
  assign mapped = reg_addr == HPRS_ADDR_CONTROL || reg_addr == HPRS_ADDR_PAT_START
    || (reg_addr >= HPRS_ADDR_RAM_PTR && reg_addr <= HPRS_ADDR_DATA_L);
  assign trig_wr = ctl_wr && reg_wdata[7] && reg_wdata[5] && !ctl_q[7]
    && reg_wdata[4:0] == HPRS_MODE_RAM_PLAYBACK;
  // Copy of the control register for trigger edge tracking
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      ctl_q <= 8'h00;
    end else if (ctl_wr) begin
      ctl_q <= reg_wdata;
    end
  end
  default clocking @(posedge mclk);
  endclocking
  default disable iff (!reset_n);
  rdata_hold_a: assert property (!reg_rd |=> $stable(reg_rdata_q))
    else $error("read data changed without a read");
  unmapped_rd_a: assert property (reg_rd && !mapped |=> reg_rdata_q == 8'h00)
    else $error("unmapped read not zero");
  ptr_readback_a: assert property (reg_wr && reg_addr == HPRS_ADDR_RAM_PTR ##2 reg_rd
    && reg_addr == HPRS_ADDR_RAM_PTR |=> reg_rdata_q == $past(reg_wdata, 3))
    else $error("pointer readback wrong");
  idle_quiet_a: assert property (!playback_busy_q && $past(playback_busy_q) == 1'b0
    |-> drive_amplitude_q == 7'h00 && !auto_brake_q)
    else $error("output active while idle");
  brake_zero_a: assert property (auto_brake_q |-> drive_amplitude_q == 7'h00)
    else $error("amplitude during brake wait");
  trig_start_a: assert property (trig_wr && !playback_busy_q |-> ##[1:3] playback_busy_q)
    else $error("trigger did not start playback");
  start_cause_a: assert property ($rose(playback_busy_q) |-> ctl_q[7] && ctl_q[5]
    && ctl_q[4:0] == HPRS_MODE_RAM_PLAYBACK)
    else $error("playback started without trigger");
  abort_stop_a: assert property (playback_busy_q && ctl_wr
    && reg_wdata[4:0] != HPRS_MODE_RAM_PLAYBACK |-> ##[1:2] !playback_busy_q)
    else $error("playback not aborted on mode change");
endmodule
bind hprs_sequencer hprs_sequencer_props #(.SLOT_CYCLES(SLOT_CYCLES)) props_u (.mclk(mclk),
  .reset_n(reset_n), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q), .drive_amplitude_q(drive_amplitude_q),
  .drive_direction_q(drive_direction_q), .auto_brake_q(auto_brake_q),
  .playback_busy_q(playback_busy_q));
